// ==== hw/rotate_set_sleep_exec_consts.svh ====
// register offsets, field positions, reset values and timing counts
`ifndef ROTATE_SET_SLEEP_EXEC_CONSTS_SVH
`define ROTATE_SET_SLEEP_EXEC_CONSTS_SVH

// =====================================================================
// register byte offsets
`define OFS_INSTRUCTION   8'h00
`define OFS_WORKING       8'h04
`define OFS_STATUS        8'h08
`define OFS_BANK_SELECT   8'h0c
`define OFS_INDEX_BASE    8'h10
`define OFS_CONTROL       8'h14
`define OFS_POWER         8'h18
`define OFS_FILE_ADDR     8'h1c
`define OFS_FILE_DATA     8'h20

// =====================================================================
// status register flag positions
`define STATUS_CARRY      0
`define STATUS_ZERO       2
`define STATUS_NEGATIVE   4

// control and power register fields
`define CONTROL_EXTENDED  0
`define CONTROL_WAKE      1
`define POWER_TIMEOUT     0
`define POWER_POWERDOWN   1
`define POWER_SLEEP       2
`define POWER_BUSY        3
`define POWER_ILLEGAL     4

// =====================================================================
// opcodes and operand limits
`define OPC_ROTATE_TOP    6'h10
`define OPC_SET_TOP       7'h34
`define OPC_SLEEP_WORD    16'h0003
`define INDEXED_LIMIT     8'h5f
`define ALL_ONES          8'hff
`define ACCESS_LOW_BANK   4'h0
`define ACCESS_HIGH_BANK  4'hf

// =====================================================================
// reset values and bus answers
`define RESET_STATUS      8'h00
`define RESET_TIMEOUT     1'b1
`define RESET_POWERDOWN   1'b1
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10
`define FILE_DEPTH        4096
`define PHASE_COUNT       4

`endif

// ==== hw/rotate_set_sleep_exec_pkg.sv ====
// types shared by the execution block and its testbench
`default_nettype none
package rotate_set_sleep_exec_pkg;

  typedef enum logic [2:0]
  {
    phase_idle   = 3'b000,
    phase_decode = 3'b001,
    phase_read   = 3'b010,
    phase_proc   = 3'b011,
    phase_write  = 3'b100
  } phase_type;

  typedef enum logic [1:0]
  {
    kind_rotate  = 2'b00,
    kind_set     = 2'b01,
    kind_sleep   = 2'b10,
    kind_illegal = 2'b11
  } kind_type;

  typedef enum logic [3:0]
  {
    sel_instruction = 4'h0,
    sel_working     = 4'h1,
    sel_status      = 4'h2,
    sel_bank        = 4'h3,
    sel_index       = 4'h4,
    sel_control     = 4'h5,
    sel_power       = 4'h6,
    sel_file_addr   = 4'h7,
    sel_file_data   = 4'h8,
    sel_none        = 4'hf
  } select_type;

endpackage
`default_nettype wire

// ==== hw/file_mem_if.sv ====
// file register memory port between engine and storage
`default_nettype none
interface file_mem_if;
  logic [11:0] addr;
  logic [7:0]  wdata;
  logic        we;
  logic [7:0]  rdata;

  modport engine
  (
    output addr,
    output wdata,
    output we,
    input  rdata
  );

  modport storage
  (
    input  addr,
    input  wdata,
    input  we,
    output rdata
  );
endinterface
`default_nettype wire

// ==== hw/file_memory.sv ====
// data memory of file registers with registered read
`include "rotate_set_sleep_exec_consts.svh"
`default_nettype none
module file_memory
(
  input wire logic      aclk,
  file_mem_if.storage   port
);

  logic [7:0] cells [0:`FILE_DEPTH-1];
  logic [7:0] read_reg;

  // =====================================================================
  // write then registered read
  always_ff @(posedge aclk)
  begin
    if (port.we)
    begin
      cells[port.addr] <= port.wdata;
    end
    read_reg <= cells[port.addr];
  end

  assign port.rdata = read_reg;

endmodule
`default_nettype wire

// ==== hw/rotate_set_sleep_exec.sv ====
// rotate, set and sleep execution block with axi4-lite registers
//
// Overview of operation
// - rotate decoded from 010000, d, a, address
// - rotate right, bit 0 wraps to bit 7
// - rotate updates only negative and zero flags
// - d=0 result to working, d=1 to register
// - a=0 access bank, a=1 bank select register
// - extended set, a=0, f<=95 uses indexed addressing
// - set writes all ones, flags untouched
// - set uses bank select when a=1
// - word 0003 is the sleep instruction
// - sleep clears watchdog counter and postscaler
// - sleep clears the power-down status bit
// - sleep sets timeout bit, only those two
// - sleep mode entered in the final phase
// - watchdog wake-up clears the timeout bit
`include "rotate_set_sleep_exec_consts.svh"
`default_nettype none
module rotate_set_sleep_exec
  import rotate_set_sleep_exec_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        watchdog_wake,
  output var  logic        watchdog_clear,
  output var  logic        sleep_mode
);

  // =====================================================================
  // state
  typedef struct packed
  {
    logic        awready;
    logic        wready;
    logic        aw_full;
    logic        w_full;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    phase_type   phase;
    kind_type    kind;
    logic [15:0] instruction;
    logic [11:0] eff_addr;
    logic [7:0]  result;
    logic [7:0]  working;
    logic [7:0]  status;
    logic [3:0]  bank_select_register;
    logic [11:0] index_base;
    logic        extended;
    logic [11:0] file_addr;
    logic        timeout_status_bit;
    logic        powerdown_status_bit;
    logic        sleep_mode;
    logic        illegal;
    logic        watchdog_clear;
    logic [11:0] mem_addr;
    logic [7:0]  mem_wdata;
    logic        mem_we;
  } state_type;

  localparam state_type reset_state = '{
    phase                : phase_idle,
    kind                 : kind_illegal,
    status               : `RESET_STATUS,
    timeout_status_bit   : `RESET_TIMEOUT,
    powerdown_status_bit : `RESET_POWERDOWN,
    default              : '0
  };

  state_type   s;
  state_type   next_s;
  file_mem_if  mem ();

  // =====================================================================
  // decoding helpers
  function automatic select_type reg_select(input logic [7:0] addr);
    case (addr)
      `OFS_INSTRUCTION : reg_select = sel_instruction;
      `OFS_WORKING     : reg_select = sel_working;
      `OFS_STATUS      : reg_select = sel_status;
      `OFS_BANK_SELECT : reg_select = sel_bank;
      `OFS_INDEX_BASE  : reg_select = sel_index;
      `OFS_CONTROL     : reg_select = sel_control;
      `OFS_POWER       : reg_select = sel_power;
      `OFS_FILE_ADDR   : reg_select = sel_file_addr;
      `OFS_FILE_DATA   : reg_select = sel_file_data;
      default          : reg_select = sel_none;
    endcase
  endfunction

  function automatic logic [31:0] merge_lanes(input logic [31:0] old_value,
                                              input logic [31:0] new_value,
                                              input logic [3:0]  strobe);
    logic [31:0] merged;
    merged = old_value;
    for (int lane = 0; lane < 4; lane++)
    begin
      if (strobe[lane])
      begin
        merged[lane*8 +: 8] = new_value[lane*8 +: 8];
      end
    end
    merge_lanes = merged;
  endfunction

  function automatic kind_type decode_kind(input logic [15:0] word);
    if (word[15:10] == `OPC_ROTATE_TOP)
    begin
      decode_kind = kind_rotate;
    end
    else if (word[15:9] == `OPC_SET_TOP)
    begin
      decode_kind = kind_set;
    end
    else if (word == `OPC_SLEEP_WORD)
    begin
      decode_kind = kind_sleep;
    end
    else
    begin
      decode_kind = kind_illegal;
    end
  endfunction

  function automatic logic [11:0] operand_address(input logic [15:0] word,
                                                  input logic [3:0]  bank,
                                                  input logic [11:0] base,
                                                  input logic        ext);
    logic [7:0] f;
    f = word[7:0];
    if (word[8])
    begin
      operand_address = {bank, f};
    end
    else if (ext && f <= `INDEXED_LIMIT)
    begin
      operand_address = base + {4'h0, f};
    end
    else if (f <= `INDEXED_LIMIT)
    begin
      operand_address = {`ACCESS_LOW_BANK, f};
    end
    else
    begin
      operand_address = {`ACCESS_HIGH_BANK, f};
    end
  endfunction

  // =====================================================================
  // rotate right without carry
  logic [7:0] rotated;

  generate
    for (genvar n = 0; n < 8; n++)
    begin : gen_rotate
      assign rotated[n] = mem.rdata[(n + 1) % 8];
    end
  endgenerate

  // =====================================================================
  // next state
  always_comb
  begin
    logic [31:0] wvalue;
    select_type  wsel;
    wvalue = '0;
    wsel   = sel_none;
    next_s = s;
    next_s.mem_we         = 1'b0;
    next_s.watchdog_clear = 1'b0;
    if (s.phase == phase_idle)
    begin
      next_s.mem_addr = s.file_addr;
    end

    // write address and data capture
    if (s_axi_awvalid && s.awready)
    begin
      next_s.aw_full = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready)
    begin
      next_s.w_full = 1'b1;
      next_s.w_data = s_axi_wdata;
      next_s.w_strb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready)
    begin
      next_s.bvalid = 1'b0;
    end

    // register write
    if (s.aw_full && s.w_full && !s.bvalid)
    begin
      wsel   = reg_select(s.aw_addr);
      next_s.aw_full = 1'b0;
      next_s.w_full  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = (wsel == sel_none) ? `RESP_SLVERR : `RESP_OKAY;
      case (wsel)
        sel_instruction :
        begin
          wvalue = merge_lanes({16'h0000, s.instruction}, s.w_data, s.w_strb);
          if (s.phase == phase_idle && !s.sleep_mode)
          begin
            next_s.instruction = wvalue[15:0];
            next_s.phase       = phase_decode;
          end
        end
        sel_working :
        begin
          wvalue = merge_lanes({24'h000000, s.working}, s.w_data, s.w_strb);
          next_s.working = wvalue[7:0];
        end
        sel_status :
        begin
          wvalue = merge_lanes({24'h000000, s.status}, s.w_data, s.w_strb);
          next_s.status = wvalue[7:0];
        end
        sel_bank :
        begin
          wvalue = merge_lanes({28'h0000000, s.bank_select_register}, s.w_data, s.w_strb);
          next_s.bank_select_register = wvalue[3:0];
        end
        sel_index :
        begin
          wvalue = merge_lanes({20'h00000, s.index_base}, s.w_data, s.w_strb);
          next_s.index_base = wvalue[11:0];
        end
        sel_control :
        begin
          wvalue = merge_lanes({31'h00000000, s.extended}, s.w_data, s.w_strb);
          next_s.extended = wvalue[`CONTROL_EXTENDED];
          if (wvalue[`CONTROL_WAKE])
          begin
            next_s.sleep_mode = 1'b0;
          end
        end
        sel_file_addr :
        begin
          wvalue = merge_lanes({20'h00000, s.file_addr}, s.w_data, s.w_strb);
          next_s.file_addr = wvalue[11:0];
        end
        sel_file_data :
        begin
          if (s.phase == phase_idle && s.w_strb[0])
          begin
            next_s.mem_we    = 1'b1;
            next_s.mem_addr  = s.file_addr;
            next_s.mem_wdata = s.w_data[7:0];
          end
        end
        default :
        begin
          wvalue = '0;
        end
      endcase
    end
    next_s.awready = !next_s.aw_full;
    next_s.wready  = !next_s.w_full;

    // register read
    if (s.rvalid && s_axi_rready)
    begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s.arready)
    begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = `RESP_OKAY;
      next_s.rdata  = '0;
      case (reg_select(s_axi_araddr))
        sel_instruction : next_s.rdata[15:0] = s.instruction;
        sel_working     : next_s.rdata[7:0]  = s.working;
        sel_status      : next_s.rdata[7:0]  = s.status;
        sel_bank        : next_s.rdata[3:0]  = s.bank_select_register;
        sel_index       : next_s.rdata[11:0] = s.index_base;
        sel_control     : next_s.rdata[0]    = s.extended;
        sel_power       :
        begin
          next_s.rdata[`POWER_TIMEOUT]   = s.timeout_status_bit;
          next_s.rdata[`POWER_POWERDOWN] = s.powerdown_status_bit;
          next_s.rdata[`POWER_SLEEP]     = s.sleep_mode;
          next_s.rdata[`POWER_BUSY]      = (s.phase != phase_idle);
          next_s.rdata[`POWER_ILLEGAL]   = s.illegal;
        end
        sel_file_addr   : next_s.rdata[11:0] = s.file_addr;
        sel_file_data   : next_s.rdata[7:0]  = mem.rdata;
        default         : next_s.rresp = `RESP_SLVERR;
      endcase
    end
    next_s.arready = !next_s.rvalid;

    // four phase execution
    case (s.phase)
      phase_idle :
      begin
        next_s.kind = s.kind;
      end
      phase_decode :
      begin
        next_s.kind     = decode_kind(s.instruction);
        next_s.eff_addr = operand_address(s.instruction, s.bank_select_register,
                                          s.index_base, s.extended);
        next_s.mem_addr = next_s.eff_addr;
        next_s.illegal  = (next_s.kind == kind_illegal);
        next_s.phase    = (next_s.kind == kind_illegal) ? phase_idle : phase_read;
      end
      phase_read :
      begin
        next_s.phase = phase_proc;
      end
      phase_proc :
      begin
        next_s.result = (s.kind == kind_set) ? `ALL_ONES : rotated;
        next_s.phase  = phase_write;
      end
      phase_write :
      begin
        next_s.phase = phase_idle;
        case (s.kind)
          kind_rotate :
          begin
            next_s.status[`STATUS_NEGATIVE] = s.result[7];
            next_s.status[`STATUS_ZERO]     = (s.result == 8'h00);
            if (!s.instruction[9])
            begin
              next_s.working = s.result;
            end
            else
            begin
              next_s.mem_we    = 1'b1;
              next_s.mem_addr  = s.eff_addr;
              next_s.mem_wdata = s.result;
            end
          end
          kind_set :
          begin
            next_s.mem_we    = 1'b1;
            next_s.mem_addr  = s.eff_addr;
            next_s.mem_wdata = s.result;
          end
          kind_sleep :
          begin
            next_s.watchdog_clear       = 1'b1;
            next_s.powerdown_status_bit = 1'b0;
            next_s.timeout_status_bit   = 1'b1;
            next_s.sleep_mode           = 1'b1;
          end
          default :
          begin
            next_s.illegal = 1'b1;
          end
        endcase
      end
      default :
      begin
        next_s.phase = phase_idle;
      end
    endcase

    // wake-up from sleep
    if (s.sleep_mode && watchdog_wake)
    begin
      next_s.sleep_mode         = 1'b0;
      next_s.timeout_status_bit = 1'b0;
    end
  end

  // =====================================================================
  // state register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s <= reset_state;
    end
    else
    begin
      s <= next_s;
    end
  end

  // =====================================================================
  // memory and outputs
  assign mem.addr  = s.mem_addr;
  assign mem.wdata = s.mem_wdata;
  assign mem.we    = s.mem_we;

  file_memory u_file_memory
  (
    .aclk (aclk),
    .port (mem.storage)
  );

  assign s_axi_awready  = s.awready;
  assign s_axi_wready   = s.wready;
  assign s_axi_bresp    = s.bresp;
  assign s_axi_bvalid   = s.bvalid;
  assign s_axi_arready  = s.arready;
  assign s_axi_rdata    = s.rdata;
  assign s_axi_rresp    = s.rresp;
  assign s_axi_rvalid   = s.rvalid;
  assign watchdog_clear = s.watchdog_clear;
  assign sleep_mode     = s.sleep_mode;

endmodule
`default_nettype wire

// ==== dv/rotate_set_sleep_exec_assertions.sv ====
// port assertions for the rotate, set and sleep block
`default_nettype none
module rotate_set_sleep_exec_assertions
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        watchdog_wake,
  input wire logic        watchdog_clear,
  input wire logic        sleep_mode
);
  // =====================================================================
  // bus answers
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_bvalid_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("write answer dropped early");
  property p_rvalid_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rvalid_hold: assert property (p_rvalid_hold) else $error("read answer dropped early");
  property p_bvalid_release;
    $fell(s_axi_bvalid) |-> $past(s_axi_bready);
  endproperty
  a_bvalid_release: assert property (p_bvalid_release) else $error("write answer left without bready");
  property p_rvalid_release;
    $fell(s_axi_rvalid) |-> $past(s_axi_rready);
  endproperty
  a_rvalid_release: assert property (p_rvalid_release) else $error("read answer left without rready");
  property p_read_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer late");
  // =====================================================================
  // sleep entry and wake
  property p_clear_pulse;
    watchdog_clear |=> !watchdog_clear;
  endproperty
  a_clear_pulse: assert property (p_clear_pulse) else $error("watchdog clear not one cycle");
  property p_clear_in_sleep;
    watchdog_clear |-> sleep_mode;
  endproperty
  a_clear_in_sleep: assert property (p_clear_in_sleep) else $error("clear without sleep");
  property p_sleep_entry;
    $rose(sleep_mode) |-> watchdog_clear && $past(s_axi_bvalid, 4) && !$past(s_axi_bvalid, 5);
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry phase wrong");
  property p_wake;
    sleep_mode && watchdog_wake |=> !sleep_mode;
  endproperty
  a_wake: assert property (p_wake) else $error("watchdog wake ignored");
  property p_sleep_leave;
    $fell(sleep_mode) |-> $past(watchdog_wake) || $rose(s_axi_bvalid);
  endproperty
  a_sleep_leave: assert property (p_sleep_leave) else $error("sleep left without cause");
  c_sleep: cover property ($rose(sleep_mode));
  c_wake: cover property (sleep_mode && watchdog_wake);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule

bind rotate_set_sleep_exec rotate_set_sleep_exec_assertions chk
(
  .aclk(aclk), .aresetn(aresetn), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .watchdog_wake(watchdog_wake), .watchdog_clear(watchdog_clear), .sleep_mode(sleep_mode)
);
`default_nettype wire

// ==== dv/test_rotate_set_sleep_exec.sv ====
// self-checking bench for the rotate, set and sleep block
`include "rotate_set_sleep_exec_consts.svh"
`default_nettype none
module test_rotate_set_sleep_exec
  import rotate_set_sleep_exec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic        awvalid = 1'b0;
  logic        awready;
  logic [31:0] wdata = 32'h0;
  logic        wvalid = 1'b0;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready = 1'b0;
  logic [7:0]  araddr = 8'h00;
  logic        arvalid = 1'b0;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready = 1'b0;
  logic        wake = 1'b0;
  logic        wclr;
  logic        slp;
  integer      seed = 32'hb2d4;
  int          err_total = 0;
  int          checks_done = 0;
  int          cycles = 0;
  int          clears = 0;
  logic [7:0]  mem [4096];
  logic [7:0]  w_m = 8'h00;
  logic [7:0]  st_m = 8'h00;
  logic [3:0]  bank_m;
  logic [11:0] idx_m;
  logic        ext_m;
  logic [4:0]  pw_m = 5'h03;

  rotate_set_sleep_exec DUT
  (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .watchdog_wake(wake),
    .watchdog_clear(wclr), .sleep_mode(slp)
  );

  // =====================================================================
  // clock, timeout and reporting
  always #10 aclk = ~aclk;
  always @(posedge aclk)
  begin
    cycles = cycles + 1;
    clears = clears + (wclr === 1'b1);
    if (cycles == 40000)
    begin
      err_total = err_total + 1;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp)
    begin
      err_total = err_total + 1;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // =====================================================================
  // bus cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit ad;
    bit wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 40; n++)
    begin
      @(posedge aclk);
      if (ad && wd && bvalid === 1'b1)
        break;
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
      ad = ad | (awready === 1'b1);
      wd = wd | (wready === 1'b1);
    end
    bready <= 1'b0;
    check("bresp", {30'h0, bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    bit ad;
    ad = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 40; n++)
    begin
      @(posedge aclk);
      if (ad && rvalid === 1'b1)
        break;
      if (arready === 1'b1)
        arvalid <= 1'b0;
      ad = ad | (arready === 1'b1);
    end
    d = rdata;
    rready <= 1'b0;
    check("rresp", {30'h0, rresp}, {30'h0, er});
  endtask
  task automatic idle();
    logic [31:0] p;
    p = 32'h8;
    for (int n = 0; n < 10 && p[3] !== 1'b0; n++)
      rd(`OFS_POWER, `RESP_OKAY, p);
  endtask
  task automatic fput(input logic [11:0] a, input logic [7:0] v);
    wr(`OFS_FILE_ADDR, {20'h0, a}, `RESP_OKAY);
    wr(`OFS_FILE_DATA, {24'h0, v}, `RESP_OKAY);
    mem[a] = v;
  endtask
  task automatic fget(input logic [11:0] a, output logic [31:0] d);
    wr(`OFS_FILE_ADDR, {20'h0, a}, `RESP_OKAY);
    repeat (2) @(posedge aclk);
    rd(`OFS_FILE_DATA, `RESP_OKAY, d);
  endtask
  task automatic power(input string what);
    logic [31:0] q;
    rd(`OFS_POWER, `RESP_OKAY, q);
    check(what, q, {27'h0, pw_m});
  endtask
  function automatic logic [11:0] ea(input logic a, input logic [7:0] f);
    if (a)
      return {bank_m, f};
    if (ext_m && f <= `INDEXED_LIMIT)
      return idx_m + {4'h0, f};
    return {(f > `INDEXED_LIMIT) ? `ACCESS_HIGH_BANK : `ACCESS_LOW_BANK, f};
  endfunction

  // =====================================================================
  // main sequence
  initial
  begin
    logic [31:0] r;
    logic [31:0] q;
    logic [7:0]  v;
    logic [7:0]  f;
    logic [7:0]  res;
    logic [11:0] ad;
    logic        d;
    logic        a;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    power("power reset");
    rd(`OFS_STATUS, `RESP_OKAY, q);
    check("status reset", q, 32'h0);
    wr(8'h24, 32'h5a, `RESP_SLVERR);
    rd(8'h24, `RESP_SLVERR, q);
    check("unmapped", q, 32'h0);
    for (int i = 0; i < 40; i++)
    begin
      r = $random(seed);
      v = (i == 2) ? 8'h00 : r[7:0];
      f = r[15:8];
      d = r[16];
      a = r[17];
      bank_m = r[21:18];
      ext_m = r[22];
      st_m = {3'h0, r[27:23]};
      idx_m = r[31:20];
      wr(`OFS_BANK_SELECT, {28'h0, bank_m}, `RESP_OKAY);
      wr(`OFS_INDEX_BASE, {20'h0, idx_m}, `RESP_OKAY);
      wr(`OFS_CONTROL, {31'h0, ext_m}, `RESP_OKAY);
      wr(`OFS_STATUS, {24'h0, st_m}, `RESP_OKAY);
      ad = ea(a, f);
      fput(ad, v);
      wr(`OFS_INSTRUCTION, i[0] ? {16'h0, `OPC_SET_TOP, a, f} : {16'h0, `OPC_ROTATE_TOP, d, a, f}, `RESP_OKAY);
      res = i[0] ? `ALL_ONES : {v[0], v[7:1]};
      if (i[0] || d)
        mem[ad] = res;
      else
        w_m = res;
      st_m[`STATUS_NEGATIVE] = i[0] ? st_m[`STATUS_NEGATIVE] : res[7];
      st_m[`STATUS_ZERO] = i[0] ? st_m[`STATUS_ZERO] : (res == 8'h00);
      idle();
      rd(`OFS_WORKING, `RESP_OKAY, q);
      check("working", q, {24'h0, w_m});
      rd(`OFS_STATUS, `RESP_OKAY, q);
      check("status", q, {24'h0, st_m});
      fget(ad, q);
      check("file", q, {24'h0, mem[ad]});
    end
    clears = 0;
    wr(`OFS_INSTRUCTION, {16'h0, `OPC_SLEEP_WORD}, `RESP_OKAY);
    idle();
    pw_m = 5'h05;
    power("power sleep");
    check("clears", clears, 32'd1);
    check("sleep", {31'h0, slp}, 32'h1);
    wr(`OFS_INSTRUCTION, {16'h0, `OPC_ROTATE_TOP, 2'b01, 8'h00}, `RESP_OKAY);
    repeat (8) @(posedge aclk);
    rd(`OFS_STATUS, `RESP_OKAY, q);
    check("status sleep", q, {24'h0, st_m});
    @(posedge aclk);
    wake <= 1'b1;
    @(posedge aclk);
    wake <= 1'b0;
    @(posedge aclk);
    check("woken", {31'h0, slp}, 32'h0);
    pw_m = 5'h00;
    power("power wake");
    wr(`OFS_INSTRUCTION, {16'h0, `OPC_SLEEP_WORD}, `RESP_OKAY);
    idle();
    pw_m = 5'h05;
    power("power resleep");
    wr(`OFS_CONTROL, {30'h0, 1'b1, ext_m}, `RESP_OKAY);
    pw_m = 5'h01;
    power("power control wake");
    wr(`OFS_INSTRUCTION, 32'hffff, `RESP_OKAY);
    idle();
    pw_m = 5'h11;
    power("power illegal");
    close_out();
  end
endmodule
`default_nettype wire
